//--- rtl/uef_pkg.sv
package uef_pkg;
	// port addresses on the eight address lines
	localparam logic [7:0] ADDR_EP1_RX = 8'h41; // endpoint 1 receive, also 16-bit dma
	localparam logic [7:0] ADDR_EP2_RX = 8'h42; // endpoint 2 receive
	localparam logic [7:0] ADDR_EP0_TX = 8'hC0; // control endpoint transmit
	localparam logic [7:0] ADDR_EP1_TX = 8'hC1; // endpoint 1 transmit
	localparam logic [7:0] ADDR_EP2_TX = 8'hC2; // endpoint 2 transmit
	localparam logic [7:0] ADDR_EP3_TX = 8'hC3; // endpoint 3 transmit
	// field positions inside the control writes seen by this block
	localparam int PKT_RDY_EP1_BIT = 1; // packet-ready flags, endpoint 1 position
	localparam int PKT_RDY_EP2_BIT = 2; // packet-ready flags, endpoint 2 position
	localparam int STALL_BIT = 1; // stall bit in endpoint control
	localparam int FLUSH_EP1_BIT = 1; // queue flush control, endpoint 1
	localparam int FLUSH_EP2_BIT = 2; // queue flush control, endpoint 2
	localparam int FLUSH_EP3_BIT = 3; // queue flush control, endpoint 3
	// queue depths in bytes
	localparam int DEPTH_BULK = 64; // bulk queues
	localparam int DEPTH_SMALL = 8; // control and interrupt queues
	// queue index order
	localparam int Q_EP1_RX = 0;
	localparam int Q_EP2_RX = 1;
	localparam int Q_EP0_TX = 2;
	localparam int Q_EP1_TX = 3;
	localparam int Q_EP2_TX = 4;
	localparam int Q_EP3_TX = 5;
	localparam int NUM_Q = 6;
	// parallel bus access, one cycle strobes
	typedef struct packed {
		logic rd; // read strobe
		logic wr; // write strobe
		logic wide; // 16-bit dma access
		logic [7:0] addr; // address lines
		logic [15:0] wdata; // write data
	} uef_bus_t;
	// events from the serial side, one cycle pulses
	typedef struct packed {
		logic [3:0] outToken; // out token per endpoint
		logic [3:0] hostAck; // host acknowledge per endpoint
		logic setupRx; // setup packet received
	} uef_usb_evt_t;
	// control writes decoded elsewhere, one cycle pulses
	typedef struct packed {
		logic pktRdyWr; // write to packet_ready_flags
		logic ep1CtlWr; // write to endpoint1_control
		logic ep2CtlWr; // write to endpoint2_control
		logic flushWr; // write to queue_flush_control
		logic [7:0] data; // value written
	} uef_ctl_wr_t;
endpackage : uef_pkg

//--- rtl/uef_queue.sv
`timescale 1ns/1ps
`default_nettype none
// byte queue with registered read data and single-cycle flush
module uef_queue #(
	parameter int DEPTH = 64
) (
	input wire logic clk, // clock
	input wire logic rstN, // synchronised reset, active low
	input wire logic flush, // empty the queue
	input wire logic push, // write one byte
	input wire logic [7:0] pushData, // byte written
	input wire logic pop, // take one byte
	output logic [7:0] popData, // registered byte taken
	output logic [7:0] popHi, // registered following byte
	output logic empty, // no byte held
	output logic full, // no room
	output logic [$clog2(DEPTH+1)-1:0] level // bytes held
);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH + 1); // width of the byte count
	logic [7:0] mem [DEPTH]; // contents left undefined at reset
	logic [AW-1:0] wrPtr_r; // write pointer
	logic [AW-1:0] rdPtr_r; // read pointer
	logic [AW-1:0] rdNext; // pointer of next byte
	logic [AW-1:0] rdAddr; // head pointer once this edge has passed
	logic [AW-1:0] hiAddr; // pointer of the byte behind that head
	logic doPush; // byte really stored
	logic doPop; // byte really taken
	assign empty = (level == '0);
	assign full = (level == LW'(DEPTH));
	assign doPush = push && !full && !flush; // flush beats push
	assign doPop = pop && !empty && !flush;
	assign rdNext = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + AW'(1);
	assign rdAddr = flush ? '0 : (doPop ? rdNext : rdPtr_r);
	assign hiAddr = (rdAddr == AW'(DEPTH - 1)) ? '0 : rdAddr + AW'(1);
	// storage, no reset so contents stay undefined
	always_ff @(posedge clk) begin
		if (doPush) begin
			mem[wrPtr_r] <= pushData;
		end
	end
	// read data look ahead to the next head, so back-to-back pops each see a
	// fresh byte; a byte stored on this edge is forwarded past the memory
	always_ff @(posedge clk) begin
		popData <= (doPush && wrPtr_r == rdAddr) ? pushData : mem[rdAddr];
		popHi <= (doPush && wrPtr_r == hiAddr) ? pushData : mem[hiAddr];
	end
	// independent pointers, flush clears both at once
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			level <= '0;
		end else if (flush) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			level <= '0;
		end else begin
			if (doPush) begin
				wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + AW'(1);
			end
			if (doPop) begin
				rdPtr_r <= rdNext;
			end
			level <= level + LW'(doPush) - LW'(doPop);
		end
	end
endmodule : uef_queue
`default_nettype wire

//--- rtl/uef_ports.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - packet-ready bit 1 write flushes ep1 receive
// - ep1 stall cleared flushes ep1 receive
// - 16-bit dma ep1 read uses 41h
// - 42h reads return successive ep2 bytes
// - ep2 transmitting ignores ep2 receive port
// - ep2 out token flushes ep2 receive
// - packet-ready bit 2 write flushes ep2 receive
// - ep2 stall cleared flushes ep2 receive
// - C0h writes load control transmit bytes
// - host ack on ep0 flushes ep0 transmit
// - setup packet flushes ep0 transmit
// - C1h writes append ep1 transmit bytes
// - ep1 receiving ignores ep1 transmit port
// - host ack on ep1 flushes ep1 transmit
// - flush bit 1 clears ep1 transmit
// - 16-bit dma ep1 write uses 41h
// - C2h writes append ep2 transmit bytes
// - ep2 receiving ignores ep2 transmit port
// - ep2 ack or flush bit 2 clears
// - C3h writes append ep3 transmit bytes
// - ep3 ack or flush bit 3 clears
// - ep1 out token flushes ep1 receive
module uef_ports #(
	parameter int BULK_DEPTH = 64, // bulk queue depth
	parameter int SMALL_DEPTH = 8 // control and interrupt queue depth
) (
	input wire logic ref_clk, // 125 MHz clock
	input wire logic rst_b, // asynchronous reset, active low
	input wire uef_pkg::uef_bus_t busReq, // parallel bus access
	input wire uef_pkg::uef_usb_evt_t usbEvt, // serial side events
	input wire uef_pkg::uef_ctl_wr_t ctlWr, // control register writes
	input wire logic ep1Transmit, // ep1 direction is transmit
	input wire logic ep2Transmit, // ep2 direction is transmit
	input wire logic [7:0] rxData, // byte from serial side
	input wire logic rxPushEp1, // store byte in ep1 receive
	input wire logic rxPushEp2, // store byte in ep2 receive
	input wire logic [3:0] txPop, // serial side takes a transmit byte
	output logic [15:0] rdData, // read data, low byte first
	output logic rdValid, // read data valid pulse
	output logic [7:0] txData0, // ep0 transmit byte
	output logic [7:0] txData1, // ep1 transmit byte
	output logic [7:0] txData2, // ep2 transmit byte
	output logic [7:0] txData3, // ep3 transmit byte
	output logic [5:0] qEmpty, // queue empty flags
	output logic [5:0] qFull, // queue full flags
	output logic ignoredAcc // pulse on an access that was ignored
);
	import uef_pkg::*;
	logic rstMeta_r; // reset synchroniser stage one
	logic rstN_r; // synchronised reset
	logic [NUM_Q-1:0] flushQ; // flush per queue
	logic [NUM_Q-1:0] pushQ; // push per queue
	logic [NUM_Q-1:0] popQ; // pop per queue
	logic [NUM_Q-1:0] emptyQ; // empty per queue
	logic [NUM_Q-1:0] fullQ; // full per queue
	logic [7:0] pushDataQ [NUM_Q]; // byte per queue
	logic [7:0] popDataQ [NUM_Q]; // registered head byte
	logic [7:0] popHiQ [NUM_Q]; // registered following byte
	logic isRead; // read strobe without write strobe, any address
	logic isWrite; // write strobe without read strobe, any address
	logic ep1RxHit; // read at 41h
	logic ep2RxHit; // access at 42h
	logic ep1TxHit; // write at C1h or wide write at 41h
	logic readGo; // a read is being served
	logic readWide; // served read is 16 bits
	logic readEp2; // served read is from ep2
	logic readGo_r; // read served last cycle
	logic readWide_r; // last read was 16 bits
	logic readEp2_r; // last read was ep2
	logic ignore; // access dropped by direction gating

	// reset release through two flops
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_r <= 1'b0;
			rstN_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstN_r <= rstMeta_r;
		end
	end

	// address decode
	always_comb begin
		isRead = busReq.rd && !busReq.wr;
		isWrite = busReq.wr && !busReq.rd;
		// the dma wide read and write share 41h with byte accesses
		ep1RxHit = isRead && (busReq.addr == ADDR_EP1_RX);
		ep1TxHit = isWrite && ((busReq.addr == ADDR_EP1_TX) ||
			(busReq.wide && busReq.addr == ADDR_EP1_RX));
		ep2RxHit = (busReq.rd || busReq.wr) && (busReq.addr == ADDR_EP2_RX);
	end

	// flush sources per queue; a flush beats a push in the same cycle
	always_comb begin
		flushQ[Q_EP1_RX] = usbEvt.outToken[1]
			|| (ctlWr.pktRdyWr && ctlWr.data[PKT_RDY_EP1_BIT])
			|| (ctlWr.ep1CtlWr && !ctlWr.data[STALL_BIT]);
		flushQ[Q_EP2_RX] = usbEvt.outToken[2]
			|| (ctlWr.pktRdyWr && ctlWr.data[PKT_RDY_EP2_BIT])
			|| (ctlWr.ep2CtlWr && !ctlWr.data[STALL_BIT]);
		flushQ[Q_EP0_TX] = usbEvt.hostAck[0]
			|| usbEvt.setupRx;
		flushQ[Q_EP1_TX] = usbEvt.hostAck[1]
			|| (ctlWr.flushWr && ctlWr.data[FLUSH_EP1_BIT]);
		flushQ[Q_EP2_TX] = usbEvt.hostAck[2]
			|| (ctlWr.flushWr && ctlWr.data[FLUSH_EP2_BIT]);
		flushQ[Q_EP3_TX] = usbEvt.hostAck[3]
			|| (ctlWr.flushWr && ctlWr.data[FLUSH_EP3_BIT]);
	end

	// pushes: receive from the serial side, transmit from the bus
	always_comb begin
		pushQ[Q_EP1_RX] = rxPushEp1 && !ep1Transmit;
		pushQ[Q_EP2_RX] = rxPushEp2 && !ep2Transmit;
		pushQ[Q_EP0_TX] = isWrite && busReq.addr == ADDR_EP0_TX;
		// a wide write pushes only its low byte here; the high byte is not stored
		pushQ[Q_EP1_TX] = ep1TxHit && !ep1Transmit ? 1'b0 : ep1TxHit;
		pushQ[Q_EP2_TX] = isWrite && busReq.addr == ADDR_EP2_TX && ep2Transmit;
		pushQ[Q_EP3_TX] = isWrite && busReq.addr == ADDR_EP3_TX;
		pushDataQ[Q_EP1_RX] = rxData;
		pushDataQ[Q_EP2_RX] = rxData;
		pushDataQ[Q_EP0_TX] = busReq.wdata[7:0];
		pushDataQ[Q_EP1_TX] = busReq.wdata[7:0];
		pushDataQ[Q_EP2_TX] = busReq.wdata[7:0];
		pushDataQ[Q_EP3_TX] = busReq.wdata[7:0];
	end

	// pops: receive from the bus, transmit from the serial side
	always_comb begin
		readGo = (ep1RxHit && !busReq.wide && ep1Transmit == 1'b0)
			|| (ep1RxHit && busReq.wide && !ep1Transmit)
			|| (ep2RxHit && isRead && !ep2Transmit);
		readWide = ep1RxHit && busReq.wide;
		readEp2 = ep2RxHit;
		popQ[Q_EP1_RX] = ep1RxHit && !ep1Transmit;
		popQ[Q_EP2_RX] = ep2RxHit && isRead && !ep2Transmit;
		popQ[Q_EP0_TX] = txPop[0];
		popQ[Q_EP1_TX] = txPop[1];
		popQ[Q_EP2_TX] = txPop[2];
		popQ[Q_EP3_TX] = txPop[3];
		// any access of a port whose direction is wrong is dropped
		ignore = (ep2RxHit && ep2Transmit)
			|| (isWrite && busReq.addr == ADDR_EP2_TX && !ep2Transmit)
			|| (ep1TxHit && !ep1Transmit)
			|| (ep1RxHit && ep1Transmit);
	end

	// six queues, one instance each
	for (genvar i = 0; i < NUM_Q; i++) begin : g_q
		localparam int D = (i == Q_EP0_TX || i == Q_EP3_TX) ? SMALL_DEPTH : BULK_DEPTH;
		uef_queue #(.DEPTH(D)) u_q (
			.clk(ref_clk),
			.rstN(rstN_r),
			.flush(flushQ[i]),
			.push(pushQ[i]),
			.pushData(pushDataQ[i]),
			// the wide read returns two bytes but pops one; a wide read in the next cycle pops none
			.pop(popQ[i] && !(i == Q_EP1_RX && readWide && readGo_r && readWide_r)),
			.popData(popDataQ[i]),
			.popHi(popHiQ[i]),
			.empty(emptyQ[i]),
			.full(fullQ[i]),
			.level()
		);
	end

	// read pipeline: queue head was sampled before the pop took effect
	always_ff @(posedge ref_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			readGo_r <= 1'b0;
			readWide_r <= 1'b0;
			readEp2_r <= 1'b0;
		end else begin
			readGo_r <= readGo;
			readWide_r <= readWide;
			readEp2_r <= readEp2;
		end
	end

	// read data register; wide read carries head byte low, next byte high
	always_ff @(posedge ref_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			rdData <= 16'h0000;
			rdValid <= 1'b0;
		end else begin
			rdValid <= readGo;
			if (readGo) begin
				if (readEp2) begin
					rdData <= {8'h00, popDataQ[Q_EP2_RX]};
				end else if (readWide) begin
					rdData <= {popHiQ[Q_EP1_RX], popDataQ[Q_EP1_RX]};
				end else begin
					rdData <= {8'h00, popDataQ[Q_EP1_RX]};
				end
			end
		end
	end

	// status and transmit bytes toward the serial side
	always_ff @(posedge ref_clk or negedge rstN_r) begin
		if (!rstN_r) begin
			qEmpty <= 6'h3F;
			qFull <= 6'h00;
			ignoredAcc <= 1'b0;
			txData0 <= 8'h00;
			txData1 <= 8'h00;
			txData2 <= 8'h00;
			txData3 <= 8'h00;
		end else begin
			qEmpty <= emptyQ;
			qFull <= fullQ;
			ignoredAcc <= ignore;
			txData0 <= popDataQ[Q_EP0_TX];
			txData1 <= popDataQ[Q_EP1_TX];
			txData2 <= popDataQ[Q_EP2_TX];
			txData3 <= popDataQ[Q_EP3_TX];
		end
	end
endmodule : uef_ports
`default_nettype wire

//--- test/uef_ports_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// watches refusals and flush timing at the block's pins
module uef_ports_monitor (
	input wire logic ref_clk, // clock
	input wire logic rst_b, // reset, active low
	input wire uef_pkg::uef_bus_t busReq, // bus access
	input wire uef_pkg::uef_usb_evt_t usbEvt, // serial events
	input wire uef_pkg::uef_ctl_wr_t ctlWr, // control writes
	input wire logic ep1Transmit, // ep1 direction
	input wire logic ep2Transmit, // ep2 direction
	input wire logic rdValid, // read data valid
	input wire logic [5:0] qEmpty, // empty flags
	input wire logic ignoredAcc // dropped access pulse
);
	import uef_pkg::*;
	// one domain, so clock and reset are given once
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	AST_EP2_READ: assert property (busReq.rd && busReq.addr == ADDR_EP2_RX && !ep2Transmit
		|=> rdValid && !ignoredAcc) else $error("ep2 read gave no data");
	AST_EP2RX_DROP: assert property (busReq.rd && busReq.addr == ADDR_EP2_RX && ep2Transmit
		|=> ignoredAcc) else $error("ep2 receive read not dropped");
	AST_EP1TX_DROP: assert property (busReq.wr && busReq.addr == ADDR_EP1_TX && !ep1Transmit
		|=> ignoredAcc) else $error("ep1 transmit write not dropped");
	AST_EP2TX_DROP: assert property (busReq.wr && busReq.addr == ADDR_EP2_TX && !ep2Transmit
		|=> ignoredAcc) else $error("ep2 transmit write not dropped");
	AST_EP3_LOAD: assert property (busReq.wr && busReq.addr == ADDR_EP3_TX
		|-> ##[1:3] !qEmpty[Q_EP3_TX]) else $error("ep3 write not stored");
	AST_OUT2_FLUSH: assert property (usbEvt.outToken[2] |-> ##[1:2] qEmpty[Q_EP2_RX])
		else $error("out token left ep2 data");
	AST_SETUP_FLUSH: assert property (usbEvt.setupRx |-> ##[1:2] qEmpty[Q_EP0_TX])
		else $error("setup left ep0 data");
	AST_ACK1_FLUSH: assert property (usbEvt.hostAck[1] |-> ##[1:2] qEmpty[Q_EP1_TX])
		else $error("ack left ep1 data");
	AST_CLR3_FLUSH: assert property (ctlWr.flushWr && ctlWr.data[FLUSH_EP3_BIT]
		|-> ##[1:2] qEmpty[Q_EP3_TX]) else $error("clear left ep3 data");
	AST_STALL1_FLUSH: assert property (ctlWr.ep1CtlWr && !ctlWr.data[STALL_BIT]
		|-> ##[1:2] qEmpty[Q_EP1_RX]) else $error("stall clear left ep1 data");
endmodule : uef_ports_monitor
bind uef_ports uef_ports_monitor i_mon (.ref_clk(ref_clk), .rst_b(rst_b), .busReq(busReq),
	.usbEvt(usbEvt), .ctlWr(ctlWr), .ep1Transmit(ep1Transmit), .ep2Transmit(ep2Transmit),
	.rdValid(rdValid), .qEmpty(qEmpty), .ignoredAcc(ignoredAcc));
`default_nettype wire

//--- test/uef_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// local controller on the parallel bus, one strobe cycle per access
module uef_mcu_model (
	input wire logic clk, // bus clock
	input wire logic [15:0] rdData, // read data from device
	input wire logic rdValid, // read data valid
	output var uef_pkg::uef_bus_t busReq // strobes toward device
);
	import uef_pkg::*;
	initial busReq = '0;
	// launch on a falling edge, release on the next; released lines show inverted
	// values so a stale address can never pass for a held one
	task automatic cyc(input logic rd, input logic wide, input logic [7:0] addr,
		input logic [15:0] wdata, output logic [15:0] d, output logic v);
		@(negedge clk);
		busReq = '{rd: rd, wr: !rd, wide: wide, addr: addr, wdata: wdata};
		@(negedge clk);
		busReq = '{rd: 1'b0, wr: 1'b0, wide: 1'b0, addr: ~addr, wdata: ~wdata};
		d = rdData;
		v = rdValid;
	endtask : cyc
endmodule : uef_mcu_model
`default_nettype wire

//--- test/uef_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uef_ports_tb;
	import uef_pkg::*;
	// address, wide/ep1Transmit/ep2Transmit/dropped nibble, queue index
	typedef struct packed {logic [7:0] a; logic [3:0] f; logic [3:0] q;} uef_row_t;
	// serial event, control write, queue that must empty
	typedef struct packed {logic [8:0] e; logic [11:0] c; logic [2:0] q;} uef_fl_t;
	logic ref_clk = 1'b0; // bench clock
	logic rst_b = 1'b0; // reset, active low
	uef_bus_t busReq; // from controller model
	uef_usb_evt_t usbEvt = '0; // serial events
	uef_ctl_wr_t ctlWr = '0; // control writes
	logic ep1T = 1'b0; // ep1 transmits
	logic ep2T = 1'b0; // ep2 transmits
	logic [7:0] rxData = 8'h00; // serial byte
	logic rxPush1 = 1'b0; // push ep1 receive
	logic rxPush2 = 1'b0; // push ep2 receive
	logic [15:0] rdData; // read data
	logic rdValid; // read valid
	logic [5:0] qEmpty; // empty flags
	logic [5:0] qFull; // full flags
	logic [7:0] txData0; // ep0 transmit byte
	logic [3:0] txPop = 4'h0; // serial side takes transmit bytes
	logic ignoredAcc; // dropped access
	logic [15:0] d; // read data seen
	logic v; // read valid seen
	int bad_count = 0; // mismatches
	int num_checks = 0; // comparisons
	uef_row_t rows [7] = '{16'hC113, 16'hC214, 16'h41C3, 16'hC143, 16'hC224, 16'hC002,
		16'hC305};
	uef_fl_t fl [14] = '{{9'h040, 12'h000, 3'd0}, {9'h000, 12'h802, 3'd0},
		{9'h000, 12'h400, 3'd0}, {9'h080, 12'h000, 3'd1},
		{9'h000, 12'h804, 3'd1}, {9'h000, 12'h200, 3'd1},
		{9'h002, 12'h000, 3'd2}, {9'h001, 12'h000, 3'd2},
		{9'h004, 12'h000, 3'd3}, {9'h000, 12'h102, 3'd3},
		{9'h008, 12'h000, 3'd4}, {9'h000, 12'h104, 3'd4},
		{9'h010, 12'h000, 3'd5}, {9'h000, 12'h108, 3'd5}};
	always #4 ref_clk = ~ref_clk;
	uef_mcu_model i_mcu (.clk(ref_clk), .rdData(rdData), .rdValid(rdValid), .busReq(busReq));
	uef_ports i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .busReq(busReq), .usbEvt(usbEvt),
		.ctlWr(ctlWr), .ep1Transmit(ep1T), .ep2Transmit(ep2T), .rxData(rxData),
		.rxPushEp1(rxPush1), .rxPushEp2(rxPush2), .txPop(txPop), .rdData(rdData),
		.rdValid(rdValid), .txData0(txData0), .txData1(), .txData2(), .txData3(),
		.qEmpty(qEmpty), .qFull(qFull), .ignoredAcc(ignoredAcc));
	// compare and count; x matches only x
	task automatic chk(input logic [15:0] s, input logic [15:0] x);
		num_checks++;
		if (s !== x) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, x);
		end
	endtask : chk
	task automatic give_verdict();
		if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	// serial side stores one byte in receive queue q
	task automatic push(input int q, input logic [7:0] b);
		@(negedge ref_clk);
		rxData = b;
		rxPush1 = (q == 0);
		rxPush2 = (q == 1);
		@(negedge ref_clk);
		rxPush1 = 1'b0;
		rxPush2 = 1'b0;
	endtask : push
	// flags are registered, so let them settle
	task automatic settle();
		repeat (3) @(negedge ref_clk);
	endtask : settle
	// watchdog: a hang ends in the verdict as a mismatch
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		give_verdict();
	end
	initial begin
		repeat (20) @(negedge ref_clk);
		rst_b = 1'b1;
		settle();
		chk(qEmpty, 16'h003F);
		// transmit ports, accepted or dropped by direction
		foreach (rows[i]) begin
			ep1T = rows[i].f[2];
			ep2T = rows[i].f[1];
			i_mcu.cyc(1'b0, rows[i].f[3], rows[i].a, 16'h5AA5, d, v);
			chk(ignoredAcc, rows[i].f[0]);
			settle();
			chk(qEmpty[rows[i].q], rows[i].f[0]);
		end
		// every flush cause empties its queue and only that cause is applied
		foreach (fl[i]) begin
			ep1T = (fl[i].q == 3);
			ep2T = (fl[i].q == 4);
			if (fl[i].q < 2) push(fl[i].q, 8'h3C);
			else i_mcu.cyc(1'b0, 1'b0, 8'(8'hBE + fl[i].q), 16'h00C3, d, v);
			settle();
			chk(qEmpty[fl[i].q], 1'b0);
			@(negedge ref_clk);
			usbEvt = fl[i].e;
			ctlWr = fl[i].c;
			@(negedge ref_clk);
			usbEvt = '0;
			ctlWr = '0;
			settle();
			chk(qEmpty[fl[i].q], 1'b1);
		end
		// ep2 drained byte by byte in order
		ep1T = 1'b0;
		ep2T = 1'b0;
		for (int k = 1; k <= 3; k++) push(1, 8'(k * 8'h11));
		settle();
		for (int k = 1; k <= 3; k++) begin
			i_mcu.cyc(1'b1, 1'b0, ADDR_EP2_RX, 16'h0000, d, v);
			chk({v, d[7:0]}, {1'b1, 8'(k * 8'h11)});
		end
		settle();
		chk(qEmpty[Q_EP2_RX], 1'b1);
		// wide dma read at the byte address, low byte first
		push(0, 8'hA1);
		push(0, 8'hB2);
		settle();
		i_mcu.cyc(1'b1, 1'b1, ADDR_EP1_RX, 16'h0000, d, v);
		chk(d, 16'hB2A1);
		// ep2 receive port refused while ep2 transmits
		ep2T = 1'b1;
		i_mcu.cyc(1'b1, 1'b0, ADDR_EP2_RX, 16'h0000, d, v);
		chk(ignoredAcc, 1'b1);
		// control transmit bytes leave in the order written
		i_mcu.cyc(1'b0, 1'b0, ADDR_EP0_TX, 16'h0011, d, v);
		i_mcu.cyc(1'b0, 1'b0, ADDR_EP0_TX, 16'h0022, d, v);
		settle();
		chk(txData0, 16'h0011);
		@(negedge ref_clk);
		txPop = 4'h1;
		@(negedge ref_clk);
		txPop = 4'h0;
		settle();
		chk(txData0, 16'h0022);
		// the interrupt queue reports full once its depth has been written
		repeat (DEPTH_SMALL) i_mcu.cyc(1'b0, 1'b0, ADDR_EP3_TX, 16'h0033, d, v);
		settle();
		chk(qFull[Q_EP3_TX], 1'b1);
		// mid-run reset drops every queue at once and clears the pulses
		rst_b = 1'b0;
		@(negedge ref_clk);
		chk({qEmpty, qFull, rdValid, ignoredAcc}, {6'h3F, 6'h00, 1'b0, 1'b0});
		rst_b = 1'b1;
		settle();
		chk(qEmpty, 16'h003F);
		give_verdict();
	end
endmodule : uef_ports_tb
`default_nettype wire
